// *** hw/lcn_defines.svh ***
`ifndef LCN_DEFINES_SVH
`define LCN_DEFINES_SVH
// Register byte offsets
`define LCN_REG_CTRL   6'h00
`define LCN_REG_TT0    6'h04
`define LCN_REG_TT1    6'h08
`define LCN_REG_TT2    6'h0c
`define LCN_REG_INV    6'h10
`define LCN_REG_RCFG   6'h14
`define LCN_REG_QGRP   6'h18
`define LCN_REG_QIO    6'h1c
`define LCN_REG_STAT   6'h20
// Field positions
`define LCN_CTRL_RSRC  0
`define LCN_CTRL_QSRC  2
`define LCN_CTRL_QCLK  6
`define LCN_CTRL_CRA   10
`define LCN_QIO_DRV    4
`define LCN_RCFG_W     4
`define LCN_STAT_COUT  3
`define LCN_STAT_LIVE  6
`define LCN_STAT_QIN   7
`define LCN_STAT_BIG   11
// Reset values
`define LCN_RST_WORD   32'h0000_0000
`define LCN_RST_QGRP   8'he4
// Hardwired clock start-up: edges swallowed after power-up
`define LCN_HARD_HOLD  2'h3
// Clock source indices of a register cell
`define LCN_SRC_HARD   3'h0
`define LCN_SRC_RA     3'h1
`define LCN_SRC_RB     3'h2
`define LCN_SRC_INT    3'h3
`define LCN_SRC_QUAD   3'h4
`define LCN_N_SRC      5
// Bus answers
`define LCN_RESP_OKAY  2'h0
`define LCN_RESP_SLV   2'h2
`endif

// *** hw/lcn_pkg.sv ***
package lcn_pkg;
   // Whole state of the fabric top
   typedef struct packed {
      logic              aw_got;
      logic [5:0]        awaddr;
      logic              w_got;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [31:0]       ctrl;
      logic [2:0][31:0]  tt;
      logic [2:0]        inv;
      logic [11:0]       rcfg;
      logic [7:0]        qgrp;
      logic [7:0]        qio;
      logic [1:0]        hard_cnt;
      logic              hard_live;
      logic              hard_prev;
      logic [1:0]        rout_prev;
      logic [2:0]        int_prev;
      logic [3:0]        quad_prev;
   } lcn_fab_st_t;

   // Whole state of one register cell
   typedef struct packed {
      logic q;
   } lcn_rc_st_t;
endpackage

// *** hw/lcn_reg_cell.sv ***
`timescale 1ns/1ps
`include "lcn_defines.svh"
module lcn_reg_cell #(
   parameter int N_SRC = `LCN_N_SRC
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [N_SRC-1:0] src_rise,
   input  wire logic [N_SRC-1:0] src_fall,
   input  wire logic [2:0]       src_sel,
   input  wire logic             fall_edge,
   input  wire logic             d,
   input  wire logic             clk_en,
   input  wire logic             clear,
   input  wire logic             preset,
   output logic                  q
);
   lcn_pkg::lcn_rc_st_t st;
   lcn_pkg::lcn_rc_st_t next_st;
   logic                tick;

   // Clock mux then per-cell polarity; out-of-range select gives no clock
   always_comb begin
      tick = 1'b0;
      if (int'(src_sel) < N_SRC) begin
         tick = fall_edge ? src_fall[src_sel] : src_rise[src_sel]; // [RQ4] [RQ3]
      end
   end

   // Clear beats preset; both act without waiting for a clock edge
   always_comb begin
      next_st = st;
      if (clear) begin
         next_st.q = 1'b0; // [RQ1] [RQ15]
      end else if (preset) begin
         next_st.q = 1'b1; // [RQ1]
      end else if (tick && clk_en) begin
         next_st.q = d; // [RQ2]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Force overrides the stored bit at once, not at the next edge
   assign q = clear ? 1'b0 : (preset ? 1'b1 : st.q); // [RQ1] [RQ15]

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_clear_low;
      clear |-> (q == 1'b0) ##1 (st.q == 1'b0);
   endproperty
   a_clear_low: assert property (p_clear_low) else $error("clear did not force low"); // [RQ15]

   property p_preset_high;
      (preset && !clear) |-> (q == 1'b1) ##1 (st.q == 1'b1);
   endproperty
   a_preset_high: assert property (p_preset_high) else $error("preset did not force high"); // [RQ1]

   property p_hold_disabled;
      (!clear && !preset && !clk_en) |=> (st.q == $past(st.q));
   endproperty
   a_hold_disabled: assert property (p_hold_disabled) else $error("disabled cell changed"); // [RQ2]

   property p_capture_edge;
      (!clear && !preset && clk_en && tick) |=> (st.q == $past(d));
   endproperty
   a_capture_edge: assert property (p_capture_edge) else $error("cell missed its edge"); // [RQ3]

   c_fall_capture: cover property (clk_en && fall_edge && tick);
endmodule // lcn_reg_cell

// *** hw/lcn_fabric.sv ***
// Contract
// RQ1: Register cell flip-flop has asynchronous clear to low and preset to high.
// RQ2: Select control lines form a clock enable; disabled cell holds its value.
// RQ3: Each register cell picks rising or falling active clock edge on its own.
// RQ4: Register cell clock comes from hardwired, routed global, or internal logic clock.
// RQ5: Combinational cell computes any function of five inputs, one optionally inverted.
// RQ6: Cluster one holds two logic cells and one register; cluster two the reverse.
// RQ7: Hardwired clock reaches register clock muxes only, never combinational logic.
// RQ8: After power-up the hardwired clock is swallowed until its fourth cycle.
// RQ9: A grounded reserved test-reset pin bypasses the hardwired start-up swallow.
// RQ10: Both routed clocks come from pin or internal logic and feed logic too; here only routed clock A reaches the logic cells.
// RQ11: Two routed clocks, one hardwired clock; only the largest part has quadrant clocks.
// RQ12: Largest part has four quadrant clocks, pin or internal, groupable across quadrants.
// RQ13: Quadrant clocks A to D serve bottom-left, bottom-right, top-left, top-right.
// RQ14: A quadrant clock pin not used as clock works as an ordinary user pin.
// RQ15: With clear and preset both active, clear wins and output stays low.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "lcn_defines.svh"
module lcn_fabric #(
   parameter logic LARGEST = 1'b1
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        hardwired_clock,
   input  wire logic        trst_grounded,
   input  wire logic        routed_clock_a,
   input  wire logic        routed_clock_b,
   input  wire logic [3:0]  quad_pin_in,
   output logic [3:0]       quad_pin_out,
   output logic [3:0]       quad_pin_oe_n,
   output logic [3:0]       quad_clock_net,
   input  wire logic [14:0] cell_in,
   input  wire logic [2:0]  control_select_zero,
   input  wire logic [2:0]  control_select_one,
   input  wire logic [2:0]  cell_clear,
   input  wire logic [2:0]  cell_preset,
   output logic [2:0]       cell_q
);
   lcn_pkg::lcn_fab_st_t st;
   lcn_pkg::lcn_fab_st_t next_st;

   logic [2:0]  cout;
   logic [2:0]  invertible_input;
   logic        routed_a_lvl;
   logic        routed_b_lvl;
   logic [3:0]  quad_lvl;
   logic [3:0]  quad_is_clk;
   logic        hard_rise;
   logic        hard_fall;
   logic        hard_rise_g;
   logic        hard_fall_g;
   logic [1:0]  rout_lvl;
   logic [1:0]  rout_rise;
   logic [1:0]  rout_fall;
   logic [2:0]  int_lvl;
   logic [2:0]  int_rise;
   logic [2:0]  int_fall;
   logic [3:0]  quad_rise;
   logic [3:0]  quad_fall;
   logic [2:0]  rc_d;
   logic [2:0]  rc_quad;
   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic [31:0] stat_word;

   // Routed clocks: pin or an internal register output, never a loop through logic
   assign routed_a_lvl = st.ctrl[`LCN_CTRL_RSRC] ? cell_q[0] : routed_clock_a; // [RQ10]
   assign routed_b_lvl = st.ctrl[`LCN_CTRL_RSRC+1] ? cell_q[1] : routed_clock_b; // [RQ10]
   assign rout_lvl     = {routed_b_lvl, routed_a_lvl};
   assign quad_is_clk  = st.ctrl[`LCN_CTRL_QCLK +: 4];

   // Combinational cells; input four may take routed clock A, the hardwired one has no path here
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         invertible_input[k] = cell_in[5*k] ^ st.inv[k]; // [RQ5]
         cout[k] = st.tt[k][{st.ctrl[`LCN_CTRL_CRA+k] ? routed_a_lvl : cell_in[5*k+4], // [RQ10] [RQ7]
                             cell_in[5*k+1 +: 3], invertible_input[k]}]; // [RQ5]
      end
   end

   // Quadrant sources: pin only when claimed as a clock, else internal or quiet
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         quad_lvl[i] = st.ctrl[`LCN_CTRL_QSRC+i] ? cell_q[2] : (quad_is_clk[i] & quad_pin_in[i]); // [RQ12]
         quad_clock_net[i] = LARGEST ? quad_lvl[st.qgrp[2*i +: 2]] : 1'b0; // [RQ11] [RQ12] [RQ13]
      end
   end

   // Quadrant pins as user I/O; enable low while driving
   assign quad_pin_out  = st.qio[3:0];
   assign quad_pin_oe_n = ~(st.qio[`LCN_QIO_DRV +: 4] & ~quad_is_clk); // [RQ14]

   // Edge detection on inputs taken as synchronous to aclk
   assign hard_rise = hardwired_clock & ~st.hard_prev;
   assign hard_fall = ~hardwired_clock & st.hard_prev;
   assign rout_rise = rout_lvl & ~st.rout_prev;
   assign rout_fall = ~rout_lvl & st.rout_prev;
   assign int_lvl   = {cout[2], cout[2], cout[1]};
   assign int_rise  = int_lvl & ~st.int_prev;
   assign int_fall  = ~int_lvl & st.int_prev;
   assign quad_rise = quad_clock_net & ~st.quad_prev;
   assign quad_fall = ~quad_clock_net & st.quad_prev;

   // Swallow the first three hardwired cycles; the fourth rise is the first passed
   assign hard_rise_g = hard_rise & (trst_grounded | st.hard_live | (st.hard_cnt == `LCN_HARD_HOLD)); // [RQ8] [RQ9]
   assign hard_fall_g = hard_fall & (trst_grounded | st.hard_live); // [RQ8] [RQ9]

   // Cluster one: C0, C1 feed R0. Cluster two: C2 feeds R1 and R2, which swap outputs
   assign rc_d[0]  = control_select_one[0] ? cout[1] : cout[0]; // [RQ6]
   assign rc_d[1]  = control_select_one[1] ? cell_q[2] : cout[2]; // [RQ6]
   assign rc_d[2]  = control_select_one[2] ? cell_q[1] : cout[2]; // [RQ6]
   assign rc_quad  = {quad_clock_net[2], quad_clock_net[1], quad_clock_net[0]};

   // Register cells; cell i sits in quadrant i
   for (genvar g = 0; g < 3; g++) begin : g_rcell
      lcn_reg_cell #(
         .N_SRC (`LCN_N_SRC)
      ) u_cell (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .src_rise  ({rc_quad[g] & ~st.quad_prev[g], int_rise[g], rout_rise, hard_rise_g}), // [RQ4] [RQ7]
         .src_fall  ({rc_quad[g] & st.quad_prev[g] ? 1'b0 : quad_fall[g], int_fall[g], rout_fall, hard_fall_g}),
         .src_sel   (st.rcfg[`LCN_RCFG_W*g +: 3]),
         .fall_edge (st.rcfg[`LCN_RCFG_W*g+3]), // [RQ3]
         .d         (rc_d[g]),
         .clk_en    (control_select_zero[g] | control_select_one[g]), // [RQ2]
         .clear     (cell_clear[g]),
         .preset    (cell_preset[g]),
         .q         (cell_q[g])
      );
   end

   // Bus handshakes: one write and one read in flight
   assign s_axi_awready = ~st.aw_got & ~st.bvalid;
   assign s_axi_wready  = ~st.w_got & ~st.bvalid;
   assign s_axi_arready = ~st.rvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign aw_take       = s_axi_awvalid & s_axi_awready;
   assign w_take        = s_axi_wvalid & s_axi_wready;
   assign ar_take       = s_axi_arvalid & s_axi_arready;

   // Status word shows the block's own state
   always_comb begin
      stat_word = `LCN_RST_WORD;
      stat_word[2:0] = cell_q;
      stat_word[`LCN_STAT_COUT +: 3] = cout;
      stat_word[`LCN_STAT_LIVE] = st.hard_live;
      stat_word[`LCN_STAT_QIN +: 4] = quad_pin_in;
      stat_word[`LCN_STAT_BIG] = LARGEST;
   end

   // Byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Next state of the whole top
   always_comb begin
      logic [31:0] m;
      m = `LCN_RST_WORD;
      next_st = st;
      next_st.hard_prev = hardwired_clock;
      next_st.rout_prev = rout_lvl;
      next_st.int_prev  = int_lvl;
      next_st.quad_prev = quad_clock_net;
      // Count swallowed rises; the fourth one makes the clock live for good
      if (hard_rise && !st.hard_live) begin
         if (st.hard_cnt == `LCN_HARD_HOLD) begin
            next_st.hard_live = 1'b1; // [RQ8]
         end else begin
            next_st.hard_cnt = st.hard_cnt + 2'h1; // [RQ8]
         end
      end
      // Write channel: address and data in either order
      if (aw_take) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (st.aw_got && st.w_got) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = `LCN_RESP_OKAY;
         case (st.awaddr)
            `LCN_REG_CTRL: next_st.ctrl = merge(st.ctrl, st.wdata, st.wstrb);
            `LCN_REG_TT0:  next_st.tt[0] = merge(st.tt[0], st.wdata, st.wstrb);
            `LCN_REG_TT1:  next_st.tt[1] = merge(st.tt[1], st.wdata, st.wstrb);
            `LCN_REG_TT2:  next_st.tt[2] = merge(st.tt[2], st.wdata, st.wstrb);
            `LCN_REG_INV: begin
               m = merge({29'h0, st.inv}, st.wdata, st.wstrb);
               next_st.inv = m[2:0];
            end
            `LCN_REG_RCFG: begin
               m = merge({20'h0, st.rcfg}, st.wdata, st.wstrb);
               next_st.rcfg = m[11:0];
            end
            `LCN_REG_QGRP: begin
               m = merge({24'h0, st.qgrp}, st.wdata, st.wstrb);
               next_st.qgrp = m[7:0];
            end
            `LCN_REG_QIO: begin
               m = merge({24'h0, st.qio}, st.wdata, st.wstrb);
               next_st.qio = m[7:0];
            end
            `LCN_REG_STAT: next_st.bresp = `LCN_RESP_OKAY; // Read-only, write dropped
            default:       next_st.bresp = `LCN_RESP_SLV;
         endcase
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // Read channel
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (ar_take) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = `LCN_RESP_OKAY;
         case (s_axi_araddr)
            `LCN_REG_CTRL: next_st.rdata = st.ctrl;
            `LCN_REG_TT0:  next_st.rdata = st.tt[0];
            `LCN_REG_TT1:  next_st.rdata = st.tt[1];
            `LCN_REG_TT2:  next_st.rdata = st.tt[2];
            `LCN_REG_INV:  next_st.rdata = {29'h0, st.inv};
            `LCN_REG_RCFG: next_st.rdata = {20'h0, st.rcfg};
            `LCN_REG_QGRP: next_st.rdata = {24'h0, st.qgrp};
            `LCN_REG_QIO:  next_st.rdata = {24'h0, st.qio};
            `LCN_REG_STAT: next_st.rdata = stat_word;
            default: begin
               next_st.rdata = `LCN_RST_WORD;
               next_st.rresp = `LCN_RESP_SLV;
            end
         endcase
      end
   end

   // Reset is power-up for the hardwired start-up counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st      <= '0;
         st.qgrp <= `LCN_RST_QGRP;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_hard_mute;
      (!trst_grounded && !st.hard_live && st.hard_cnt != `LCN_HARD_HOLD) |-> !hard_rise_g && !hard_fall_g;
   endproperty
   a_hard_mute: assert property (p_hard_mute) else $error("hardwired clock leaked early"); // [RQ8]

   property p_hard_fourth;
      (!st.hard_live && st.hard_cnt == `LCN_HARD_HOLD && hard_rise) |-> hard_rise_g ##1 st.hard_live;
   endproperty
   a_hard_fourth: assert property (p_hard_fourth) else $error("fourth hardwired edge lost"); // [RQ8]

   property p_bypass;
      (trst_grounded && hard_rise) |-> hard_rise_g;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not pass first edge"); // [RQ9]

   property p_routed_logic;
      st.ctrl[`LCN_CTRL_CRA] |-> cout[0] == st.tt[0][{routed_a_lvl, cell_in[3:1], invertible_input[0]}];
   endproperty
   a_routed_logic: assert property (p_routed_logic) else $error("routed clock not seen by logic"); // [RQ10]

   property p_small_part;
      !LARGEST |-> quad_clock_net == 4'h0;
   endproperty
   a_small_part: assert property (p_small_part) else $error("quadrant clock on small part"); // [RQ11]

   property p_quad_map;
      (LARGEST && st.qgrp == `LCN_RST_QGRP) |-> quad_clock_net == quad_lvl;
   endproperty
   a_quad_map: assert property (p_quad_map) else $error("quadrant order wrong"); // [RQ13]

   property p_user_pin;
      (|quad_is_clk) |-> (quad_pin_oe_n & quad_is_clk) == quad_is_clk;
   endproperty
   a_user_pin: assert property (p_user_pin) else $error("clock pin driven as output"); // [RQ14]

   property p_write_answer;
      (st.aw_got && st.w_got && !st.bvalid) |=> st.bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write not answered");

   c_hard_live: cover property ($rose(st.hard_live));
   c_write:     cover property (st.bvalid && s_axi_bready);
   c_read_stat: cover property (ar_take && s_axi_araddr == `LCN_REG_STAT);
endmodule // lcn_fabric

// *** tb/logic_cell_clock_network_bench.sv ***
`timescale 1ns/1ps
`include "lcn_defines.svh"
module logic_cell_clock_network_bench;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        hard_clk, trst_gnd, rclk_a, rclk_b;
   logic [3:0]  qin, qout, qoe_n, qnet;
   logic [14:0] cell_in;
   logic [2:0]  cs0, cs1, clr, pre, cell_q;
   int          error_cnt = 0;
   int          n_tests = 0;

   lcn_fabric DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hardwired_clock(hard_clk),
      .trst_grounded(trst_gnd), .routed_clock_a(rclk_a), .routed_clock_b(rclk_b), .quad_pin_in(qin),
      .quad_pin_out(qout), .quad_pin_oe_n(qoe_n), .quad_clock_net(qnet), .cell_in(cell_in),
      .control_select_zero(cs0), .control_select_one(cs1), .cell_clear(clr), .cell_preset(pre),
      .cell_q(cell_q));

   // Free-running 100 MHz clock
   always #5 aclk = ~aclk;

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Address and data offered together; each released once taken, bready held until bvalid
   task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] exp);
      int i;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            chk("bresp", {30'h0, exp}, {30'h0, bresp});
            break;
         end
      end
      if (i == 100) begin error_cnt++; summarize(); end
   endtask

   task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata; r = rresp; rready <= 1'b0;
            break;
         end
      end
      if (i == 100) begin error_cnt++; summarize(); end
   endtask

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      cyc(2);
      aresetn <= 1'b1;
   endtask

   // Slow square pulse on the hardwired pin or on routed clock A, each level held four cycles
   task automatic pulse(input logic on_hard);
      @(posedge aclk);
      if (on_hard) hard_clk <= 1'b1; else rclk_a <= 1'b1;
      cyc(4);
      if (on_hard) hard_clk <= 1'b0; else rclk_a <= 1'b0;
      cyc(4);
   endtask

   task automatic reset_values;
      logic [31:0] d; logic [1:0] r;
      for (int a = 0; a < 8; a++) begin
         axi_rd(6'(a * 4), d, r);
         chk("reset word", (a == 6) ? 32'h0000_00e4 : 32'h0, d);
         chk("read resp", {30'h0, `LCN_RESP_OKAY}, {30'h0, r});
      end
      axi_rd(`LCN_REG_STAT, d, r);
      chk("largest flag", 32'h1, {31'h0, d[11]});
      axi_rd(6'h24, d, r);
      chk("unmapped data", 32'h0, d);
      chk("unmapped resp", {30'h0, `LCN_RESP_SLV}, {30'h0, r});
      axi_wr(6'h3c, 32'h1, `LCN_RESP_SLV);
      axi_wr(`LCN_REG_STAT, 32'hffff_ffff, `LCN_RESP_OKAY);
   endtask

   // Cell 0 on the hardwired clock: the fourth rise after power-up loads it, or the first rise with the test-reset bypass
   task automatic hard_start(input logic bypass);
      int need;
      need = bypass ? 1 : 4;
      trst_gnd <= bypass;
      do_reset();
      axi_wr(`LCN_REG_TT0, 32'hffff_ffff, `LCN_RESP_OKAY);
      cs0 <= 3'b001;
      for (int n = 1; n <= 4; n++) begin
         pulse(1'b1);
         chk("hard load", {31'h0, n >= need}, {31'h0, cell_q[0]});
      end
      cs0 <= 3'b000;
   endtask

   // Three-input parity in one logic cell, with and without the input inverter
   task automatic comb_cell;
      logic [31:0] d; logic [1:0] r;
      axi_wr(`LCN_REG_TT0, 32'h9696_9696, `LCN_RESP_OKAY);
      for (int inv = 0; inv < 2; inv++) begin
         axi_wr(`LCN_REG_INV, 32'(inv), `LCN_RESP_OKAY);
         for (int v = 0; v < 8; v++) begin
            @(posedge aclk);
            cell_in <= 15'(v);
            axi_rd(`LCN_REG_STAT, d, r);
            chk("parity out", {31'h0, ^3'(v) ^ inv[0]}, {31'h0, d[3]});
         end
      end
      // Routed clock A as input four of logic cell 0; upper half of the table is ones
      axi_wr(`LCN_REG_TT0, 32'hffff_0000, `LCN_RESP_OKAY);
      axi_wr(`LCN_REG_CTRL, 32'h0000_0400, `LCN_RESP_OKAY);
      for (int lvl = 0; lvl < 2; lvl++) begin
         @(posedge aclk);
         rclk_a <= lvl[0];
         axi_rd(`LCN_REG_STAT, d, r);
         chk("routed into logic", 32'(lvl), {31'h0, d[3]});
      end
      @(posedge aclk);
      rclk_a <= 1'b0;
   endtask

   task automatic quad;
      logic [31:0] d; logic [1:0] r;
      qin <= 4'b1010;
      axi_wr(`LCN_REG_CTRL, 32'h0000_03c0, `LCN_RESP_OKAY);
      cyc(2); #1;
      chk("quad nets", 32'ha, {28'h0, qnet});
      axi_wr(`LCN_REG_QIO, 32'h0000_00f5, `LCN_RESP_OKAY);
      #1;
      chk("claimed pins", 32'hf5, {24'h0, qoe_n, qout});
      axi_wr(`LCN_REG_CTRL, 32'h0, `LCN_RESP_OKAY);
      #1;
      chk("user pins", 32'h05, {24'h0, qoe_n, qout});
      axi_rd(`LCN_REG_STAT, d, r);
      chk("pin inputs", 32'ha, {28'h0, d[10:7]});
      axi_wr(`LCN_REG_CTRL, 32'h0000_03c0, `LCN_RESP_OKAY);
      axi_wr(`LCN_REG_QGRP, 32'h0, `LCN_RESP_OKAY);
      @(posedge aclk); qin <= 4'b1011;
      cyc(2); #1;
      chk("grouped nets", 32'hf, {28'h0, qnet});
   endtask

   task automatic clr_pre;
      @(posedge aclk); pre <= 3'b010; #1;
      chk("preset", 32'h1, {31'h0, cell_q[1]});
      @(posedge aclk); clr <= 3'b010; #1;
      chk("both", 32'h0, {31'h0, cell_q[1]});
      @(posedge aclk); pre <= 3'b000; cyc(2); #1;
      chk("clear held", 32'h0, {31'h0, cell_q[1]});
      @(posedge aclk); clr <= 3'b000; cyc(2); #1;
      chk("clear kept", 32'h0, {31'h0, cell_q[1]});
   endtask

   // Cell 2 on routed clock A, falling edge, gated by the select lines; then cell 0 on routed clock B
   task automatic routed;
      do_reset();
      axi_wr(`LCN_REG_TT2, 32'hffff_ffff, `LCN_RESP_OKAY);
      axi_wr(`LCN_REG_RCFG, 32'h0000_0900, `LCN_RESP_OKAY);
      pulse(1'b0);
      chk("disabled", 32'h0, {31'h0, cell_q[2]});
      cs0 <= 3'b100;
      @(posedge aclk); rclk_a <= 1'b1; cyc(4);
      chk("rise ignored", 32'h0, {31'h0, cell_q[2]});
      rclk_a <= 1'b0; cyc(4);
      chk("fall loads", 32'h1, {31'h0, cell_q[2]});
      cs0 <= 3'b000;
      // Logic cell 0 stays zero, so only select line one can load cell 0 with logic cell 1
      axi_wr(`LCN_REG_TT1, 32'hffff_ffff, `LCN_RESP_OKAY);
      axi_wr(`LCN_REG_RCFG, 32'h0000_0902, `LCN_RESP_OKAY);
      cs1 <= 3'b001;
      @(posedge aclk); rclk_b <= 1'b1; cyc(4);
      chk("alternate data", 32'h1, {31'h0, cell_q[0]});
      cs1 <= 3'b000;
      rclk_b <= 1'b0;
   endtask

   initial begin
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; hard_clk = 0; trst_gnd = 0;
      rclk_a = 0; rclk_b = 0; qin = 0; cell_in = 0; cs0 = 0; cs1 = 0; clr = 0; pre = 0;
      cyc(2);
      aresetn <= 1'b1;
      reset_values();
      hard_start(1'b0);
      comb_cell();
      quad();
      clr_pre();
      routed();
      hard_start(1'b1);
      summarize();
   end
endmodule // logic_cell_clock_network_bench
